// ### bench/ats_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ats_host_model
    import ats_pkg::*;
(
    // clock
    input  wire logic           clk,
    // converter side
    input  wire logic           convStrobe,
    input  wire logic           slow,
    output logic                sampleValid,
    output logic [SAMPLE_W-1:0] sampleData,
    // network side
    input  wire logic           stall,
    output logic                pktReady
);
    logic [SAMPLE_W-1:0] nextWord;
    int                  due;

    initial
    begin
        sampleValid = 1'b0;
        sampleData  = 16'h0000;
        nextWord    = 16'h0100;
        pktReady    = 1'b0;
        due         = 0;
    end

    ////////////////////////////////////////
    // a scan answers two or five cycles after its strobe
    always @(posedge clk)
        if (convStrobe === 1'b1)
            due <= slow ? 5 : 2;
        else if (due > 0)
            due <= due - 1;

    always @(negedge clk)
    begin
        pktReady <= !stall;
        if (due == 1)
        begin
            sampleValid <= 1'b1;
            sampleData  <= nextWord;
            nextWord    <= nextWord + 16'h0001;
        end
        else
        begin
            sampleValid <= 1'b0;
            // idle bus toggles so a stale word can never pass as fresh
            sampleData  <= ~sampleData;
        end
    end
endmodule // ats_host_model
`default_nettype wire

// ### bench/test_acquisition_trigger_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_acquisition_trigger_sequencer
    import ats_pkg::*;
;
    logic                clk = 1'b0;
    logic                arst_n = 1'b0;
    logic                cmdStart = 1'b0, cmdStop = 1'b0, cmdRead = 1'b0, cmdParam = 1'b0;
    logic                connReq = 1'b0, connRelease = 1'b0, trigPin = 1'b1;
    logic                cfgNSample = 1'b0, cfgTrigIsCounter = 1'b0;
    ats_trig_t           cfgTrig = TRG_SOFT;
    logic [RATE_W-1:0]   cfgRateHz = RATE_RST;
    logic [CNT_W-1:0]    cfgCount = 25'h0000010;
    logic [DELAY_W-1:0]  cfgDelayCyc = 32'h00000190;
    logic                convStrobe, sampleValid, pktValid, pktReady, pktLast;
    logic                connGrant, connRefused, cfgError, overflow;
    logic                stall = 1'b0, slow = 1'b0, lastChk = 1'b1;
    logic [SAMPLE_W-1:0] sampleData, pktData;
    logic [CNT_W-1:0]    samplesTaken;
    ats_state_t          state;
    logic [7:0]          rnd = 8'h60;
    logic [SAMPLE_W-1:0] expq [$];
    int                  err_count = 0, compares = 0, strobes = 0, words = 0, s;

    ats_sequencer dut (.clk(clk), .arst_n(arst_n), .cmdStart(cmdStart), .cmdStop(cmdStop),
        .cmdRead(cmdRead), .cmdParam(cmdParam), .cfgNSample(cfgNSample), .cfgTrig(cfgTrig),
        .cfgRateHz(cfgRateHz), .cfgCount(cfgCount), .cfgDelayCyc(cfgDelayCyc),
        .cfgTrigIsCounter(cfgTrigIsCounter), .connReq(connReq), .connRelease(connRelease),
        .connGrant(connGrant), .connRefused(connRefused), .trigPin(trigPin),
        .convStrobe(convStrobe), .sampleValid(sampleValid), .sampleData(sampleData),
        .pktValid(pktValid), .pktReady(pktReady), .pktData(pktData), .pktLast(pktLast),
        .state(state), .cfgError(cfgError), .samplesTaken(samplesTaken), .overflow(overflow));

    ats_host_model host (.clk(clk), .convStrobe(convStrobe), .slow(slow),
        .sampleValid(sampleValid), .sampleData(sampleData), .stall(stall), .pktReady(pktReady));

    always #25 clk = ~clk;

    ////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic note(input string t);
        $display("test %s done", t);
    endtask

    // k: 0 param, 1 start, 2 stop, 3 read, 4 connect, 5 release
    task automatic cmd(input int k);
        @(negedge clk);
        {cmdParam, cmdStart, cmdStop, cmdRead, connReq, connRelease} = 6'h20 >> k;
        @(negedge clk);
        {cmdParam, cmdStart, cmdStop, cmdRead, connReq, connRelease} = 6'h00;
        @(negedge clk);
    endtask

    task automatic setp(input logic ns, input ats_trig_t t, input int r, input int c,
                        input logic ctr, input logic e);
        cfgNSample = ns;
        cfgTrig = t;
        cfgRateHz = r[RATE_W-1:0];
        cfgCount = c[CNT_W-1:0];
        cfgTrigIsCounter = ctr;
        cmd(0);
        chk("cfgError", {31'h0, e}, {31'h0, cfgError});
    endtask

    task automatic waitst(input ats_state_t w, input int n);
        repeat (n) if (state !== w) @(negedge clk);
    endtask

    // 30 kHz source, edges kept off the clock grid
    task automatic trigFall();
        #7 trigPin = 1'b0;
        #16660 trigPin = 1'b1;
        #16673;
    endtask

    task automatic drain(input logic rd);
        repeat (8) @(negedge clk);
        if (rd)
            cmd(3);
        repeat (4000) if (expq.size() != 0) @(negedge clk);
        repeat (4) @(negedge clk);
        chk("pending", 0, expq.size());
        chk("pktValid", 0, {31'h0, pktValid});
    endtask

    ////////////////////////////////////////
    always @(negedge clk)
    begin
        rnd <= lfsr(rnd);
        stall <= rnd[0] & rnd[1];
        slow <= rnd[2];
    end

    always @(posedge clk)
        if (convStrobe === 1'b1)
            strobes <= strobes + 1;

    // a full buffer refuses, so only the first words in stay noted
    always @(posedge clk)
    begin
        // a full buffer refuses even while a word leaves at the same edge
        automatic bit keep = sampleValid === 1'b1 && expq.size() < FIFO_DEPTH;
        if ((pktValid & pktReady) === 1'b1)
        begin
            chk("queued", 1, expq.size() != 0);
            if (expq.size() != 0)
                chk("pktData", expq.pop_front(), pktData);
            if (lastChk)
                chk("pktLast", words % 16 == 15, pktLast);
            words++;
        end
        if (keep)
            expq.push_back(sampleData);
    end

    initial
    begin
        repeat (80000) @(posedge clk);
        err_count++;
        $display("Error watchdog expected finish seen timeout");
        final_report();
    end

    initial
    begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        chk("state", ST_IDLE, state);
        setp(0, TRG_PRE, 1000, 16, 0, 1);
        setp(1, TRG_EXTCK, 1000, 16, 0, 1);
        setp(0, TRG_SOFT, 30001, 16, 0, 1);
        setp(1, TRG_SOFT, 200001, 16, 0, 1);
        setp(1, TRG_SOFT, 0, 16, 0, 1);
        setp(1, TRG_SOFT, 1000, 30000001, 0, 1);
        setp(1, TRG_POST, 1000, 16, 1, 1);
        setp(0, TRG_EXTCK, 1000, 16, 1, 1);
        setp(0, TRG_SOFT, 1000, 16, 1, 0);
        setp(1, TRG_SOFT, 200000, 30000000, 0, 0);
        setp(0, TRG_SOFT, 1, 16, 0, 0);
        setp(0, TRG_SOFT, 30000, 16, 0, 0);
        cmd(1);
        chk("state", ST_IDLE, state);
        note("config");
        cmd(4);
        chk("connGrant", 1, {31'h0, connGrant});
        @(negedge clk);
        connReq = 1'b1;
        #1 chk("connRefused", 1, {31'h0, connRefused});
        @(negedge clk);
        connReq = 1'b0;
        #1 chk("connGrant", 1, {31'h0, connGrant});
        note("connection");
        strobes = 0;
        cmd(1);
        chk("state", ST_CONVERT, state);
        cmd(1);
        chk("state", ST_CONVERT, state);
        s = strobes;
        repeat (6660) @(negedge clk);
        chk("rate", 1, (strobes - s) inside {[9:11]});
        repeat (30000) if (strobes < 32) @(negedge clk);
        cmd(2);
        chk("state", ST_IDLE, state);
        drain(0);
        repeat (700) @(negedge clk);
        chk("strobes", 32, strobes);
        chk("words", 32, words);
        note("continuous");
        setp(0, TRG_EXTCK, 1000, 16, 0, 0);
        strobes = 0;
        cmd(1);
        chk("state", ST_ARMED, state);
        chk("strobes", 0, strobes);
        repeat (16) trigFall();
        chk("state", ST_CONVERT, state);
        chk("strobes", 16, strobes);
        cmd(2);
        drain(0);
        chk("words", 48, words);
        note("external clock");
        setp(1, TRG_SOFT, 200000, 40, 0, 0);
        strobes = 0;
        cmd(1);
        waitst(ST_DONE, 6000);
        repeat (20) @(negedge clk);
        chk("strobes", 40, strobes);
        chk("samplesTaken", 40, samplesTaken);
        chk("overflow", 1, {31'h0, overflow});
        chk("pktValid", 0, {31'h0, pktValid});
        cmd(2);
        chk("state", ST_DONE, state);
        drain(1);
        chk("words", 80, words);
        note("count limited");
        setp(1, TRG_POST, 200000, 16, 0, 0);
        strobes = 0;
        cmd(1);
        repeat (300) @(negedge clk);
        chk("state", ST_ARMED, state);
        chk("strobes", 0, strobes);
        trigFall();
        waitst(ST_DONE, 2000);
        chk("strobes", 16, strobes);
        drain(1);
        note("post trigger");
        setp(1, TRG_DELAY, 200000, 16, 0, 0);
        strobes = 0;
        cmd(1);
        trigPin = 1'b0;
        repeat (10) @(negedge clk);
        chk("state", ST_DELAY, state);
        repeat (380) @(negedge clk);
        chk("strobes", 0, strobes);
        repeat (30) @(negedge clk);
        chk("state", ST_CONVERT, state);
        trigPin = 1'b1;
        waitst(ST_DONE, 2000);
        chk("strobes", 16, strobes);
        drain(1);
        note("delay trigger");
        setp(1, TRG_PRE, 200000, 16, 0, 0);
        lastChk = 1'b0;
        cmd(1);
        chk("state", ST_CONVERT, state);
        repeat (2000) @(negedge clk);
        chk("state", ST_CONVERT, state);
        chk("samplesTaken", 1, samplesTaken > 16);
        trigFall();
        chk("state", ST_DONE, state);
        s = strobes;
        repeat (300) @(negedge clk);
        chk("strobes", s, strobes);
        drain(1);
        cmd(5);
        chk("connGrant", 0, {31'h0, connGrant});
        note("pre trigger");
        final_report();
    end
endmodule // test_acquisition_trigger_sequencer
`default_nettype wire

// ### common/ats_pkg.sv
// Behaviour
// RQ1 - two modes; triggers limited per mode
// RQ2 - continuous software: start begins paced conversion
// RQ3 - packet of samples returned, acquisition continues
// RQ4 - continuous runs until stop command
// RQ5 - continuous software rate 1 Hz to 30 kHz
// RQ6 - external clock: start arms, one scan per edge
// RQ7 - external clock kept between 1 Hz and 30 kHz; the design does not check it, the rate limits skip TRG_EXTCK
// RQ8 - N-sample software: stop at count, hold data
// RQ9 - N-sample rate 1 Hz to 200 kHz
// RQ10 - sample count up to 30,000,000
// RQ11 - pre-trigger: convert until trigger event
// RQ12 - post-trigger: start arms, trigger starts conversion
// RQ13 - delay-trigger: wait delay, then convert to count
// RQ14 - host sets delay before start
// RQ15 - trigger recognised on falling edge
// RQ16 - single host connection at a time
// RQ17 - counter use disables external trigger modes
// RQ18 - trigger input two-stage synchronised
// RQ19 - start ignored when active; stop returns idle; the design ignores stop in done
package ats_pkg;
    localparam int unsigned CLK_HZ       = 20000000;
    localparam int unsigned CONT_MAX_HZ  = 30000;
    localparam int unsigned NSAMP_MAX_HZ = 200000;
    localparam int unsigned MIN_HZ       = 1;
    localparam int unsigned COUNT_MAX    = 30000000;
    localparam int unsigned RATE_W       = 18;
    localparam int unsigned CNT_W        = 25;
    localparam int unsigned DIV_W        = 25;
    localparam int unsigned DELAY_W      = 32;
    localparam int unsigned SAMPLE_W     = 16;
    localparam int unsigned FIFO_DEPTH   = 32;
    localparam int unsigned PKT_WORDS    = 16;
    localparam logic [RATE_W-1:0] RATE_RST = 18'h003E8;

    typedef enum logic [2:0]
    {
        TRG_SOFT  = 3'h0,
        TRG_EXTCK = 3'h1,
        TRG_PRE   = 3'h2,
        TRG_POST  = 3'h3,
        TRG_DELAY = 3'h4
    } ats_trig_t;

    typedef enum logic [2:0]
    {
        ST_IDLE    = 3'h0,
        ST_ARMED   = 3'h1,
        ST_DELAY   = 3'h2,
        ST_CONVERT = 3'h3,
        ST_DONE    = 3'h4
    } ats_state_t;
endpackage

// ### hw/ats_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ats_fifo
#(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 32
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData,
    output logic [$clog2(DEPTH):0] level
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic             push, pop;

    always_comb
    begin
        push     = inValid && inReady;
        pop      = outValid && outReady;
        wrPtr_d  = push ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d  = pop ? rdPtr_q + 1'b1 : rdPtr_q;
        level    = wrPtr_q - rdPtr_q;
        inReady  = level != (AW+1)'(DEPTH);
        outValid = level != '0;
        outData  = mem[rdPtr_q[AW-1:0]];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
    end

    // storage needs no reset; validity comes from the pointers
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr_q[AW-1:0]] <= inData;
        end
    end
endmodule // ats_fifo
`default_nettype wire

// ### hw/ats_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module ats_sequencer
    import ats_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // host commands, one-cycle pulses
    input  wire logic                cmdStart,
    input  wire logic                cmdStop,
    input  wire logic                cmdRead,
    input  wire logic                cmdParam,
    // host configuration, taken on cmdParam
    input  wire logic                cfgNSample,
    input  wire ats_trig_t           cfgTrig,
    input  wire logic [RATE_W-1:0]   cfgRateHz,
    input  wire logic [CNT_W-1:0]    cfgCount,
    input  wire logic [DELAY_W-1:0]  cfgDelayCyc,
    input  wire logic                cfgTrigIsCounter,
    // host connection arbitration
    input  wire logic                connReq,
    input  wire logic                connRelease,
    output logic                     connGrant,
    output logic                     connRefused,
    // trigger pin pair, already received differentially
    input  wire logic                trigPin,
    // converter sample path
    output logic                     convStrobe,
    input  wire logic                sampleValid,
    input  wire logic [SAMPLE_W-1:0] sampleData,
    // data stream toward the network side
    output logic                     pktValid,
    input  wire logic                pktReady,
    output logic [SAMPLE_W-1:0]      pktData,
    output logic                     pktLast,
    // status
    output ats_state_t               state,
    output logic                     cfgError,
    output logic [CNT_W-1:0]         samplesTaken,
    output logic                     overflow
);
    ////////////////////////////////////////////////////////////////////
    // configuration
    logic                cfgN_q, cfgN_d;
    ats_trig_t           trig_q, trig_d;
    logic [RATE_W-1:0]   rate_q, rate_d;
    logic [CNT_W-1:0]    count_q, count_d;
    logic [DELAY_W-1:0]  delay_q, delay_d;
    logic                err_q, err_d;
    logic                cfgOk;
    logic [DIV_W-1:0]    maxHz;
    ats_state_t          state_q, state_d;

    always_comb
    begin
        maxHz = cfgNSample ? DIV_W'(NSAMP_MAX_HZ) : DIV_W'(CONT_MAX_HZ);
        cfgOk = (DIV_W'(cfgRateHz) <= maxHz || cfgTrig == TRG_EXTCK) // RQ5 RQ9
             && (cfgRateHz >= RATE_W'(MIN_HZ) || cfgTrig == TRG_EXTCK)
             && (DIV_W'(cfgCount) <= DIV_W'(COUNT_MAX)) // RQ10
             && (cfgNSample ? cfgTrig != TRG_EXTCK // RQ1
                            : (cfgTrig == TRG_SOFT || cfgTrig == TRG_EXTCK))
             && !(cfgTrigIsCounter && cfgTrig != TRG_SOFT) // RQ17
             && cfgTrig inside {TRG_SOFT, TRG_EXTCK, TRG_PRE, TRG_POST, TRG_DELAY}; // RQ1
        cfgN_d  = cfgN_q;
        trig_d  = trig_q;
        rate_d  = rate_q;
        count_d = count_q;
        delay_d = delay_q;
        err_d   = err_q;
        // parameters change only in idle or done so a run never sees a half update
        if (cmdParam && (state_q == ST_IDLE || state_q == ST_DONE))
        begin
            err_d = !cfgOk;
            if (cfgOk)
            begin
                cfgN_d  = cfgNSample;
                trig_d  = cfgTrig;
                rate_d  = cfgRateHz;
                count_d = cfgCount;
                delay_d = cfgDelayCyc; // RQ14
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cfgN_q  <= 1'b0;
            trig_q  <= TRG_SOFT;
            rate_q  <= RATE_RST;
            count_q <= '0;
            delay_q <= '0;
            err_q   <= 1'b0;
        end
        else
        begin
            cfgN_q  <= cfgN_d;
            trig_q  <= trig_d;
            rate_q  <= rate_d;
            count_q <= count_d;
            delay_q <= delay_d;
            err_q   <= err_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // connection and trigger input
    logic conn_q, conn_d;
    logic sync1_q, sync2_q, sync3_q;
    logic trigFall;

    always_comb
    begin
        conn_d = conn_q;
        if (connRelease)
        begin
            conn_d = 1'b0;
        end
        else if (connReq)
        begin
            conn_d = 1'b1;
        end
        connRefused = connReq && conn_q; // RQ16
        trigFall    = sync3_q && !sync2_q; // RQ15
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            conn_q  <= 1'b0;
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            sync3_q <= 1'b1;
        end
        else
        begin
            conn_q  <= conn_d;
            sync1_q <= trigPin; // RQ18
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    logic [DIV_W-1:0]    div_q, div_d, divTop;
    logic [DELAY_W-1:0]  dly_q, dly_d;
    logic [CNT_W-1:0]    taken_q, taken_d;
    logic [4:0]          pkt_q, pkt_d;
    logic                ovf_q, ovf_d;
    logic                pace, fifoReady, fifoValid, lastHit;

    always_comb
    begin
        divTop   = DIV_W'(CLK_HZ / ((rate_q == '0) ? 1 : 32'(rate_q)) - 1);
        state_d  = state_q;
        div_d    = div_q;
        dly_d    = dly_q;
        taken_d  = taken_q;
        ovf_d    = ovf_q;
        pace     = 1'b0;
        lastHit  = 1'b0;
        unique case (state_q)
            ST_IDLE, ST_DONE:
            begin
                if (cmdStart && conn_q && !cmdStop)
                begin
                    taken_d = '0;
                    div_d   = '0;
                    dly_d   = delay_q;
                    ovf_d   = 1'b0;
                    if (trig_q == TRG_EXTCK || trig_q == TRG_POST || trig_q == TRG_DELAY)
                    begin
                        state_d = ST_ARMED; // RQ6 RQ12
                    end
                    else
                    begin
                        state_d = ST_CONVERT; // RQ2 RQ8 RQ11
                    end
                end
            end
            ST_ARMED:
            begin
                if (trigFall)
                begin
                    if (trig_q == TRG_EXTCK)
                    begin
                        pace    = 1'b1; // RQ6
                        state_d = ST_CONVERT;
                    end
                    else if (trig_q == TRG_DELAY && delay_q != '0)
                    begin
                        state_d = ST_DELAY; // RQ13
                    end
                    else
                    begin
                        state_d = ST_CONVERT; // RQ12
                    end
                end
            end
            ST_DELAY:
            begin
                dly_d = dly_q - 1'b1;
                if (dly_q <= DELAY_W'(1))
                begin
                    state_d = ST_CONVERT; // RQ13
                end
            end
            ST_CONVERT:
            begin
                if (trig_q == TRG_EXTCK)
                begin
                    pace = trigFall; // RQ6
                end
                else
                begin
                    pace  = div_q == '0; // RQ2
                    div_d = pace ? divTop : div_q - 1'b1;
                end
                if (trig_q == TRG_PRE && trigFall)
                begin
                    state_d = ST_DONE; // RQ11
                    pace    = 1'b0;
                end
                else if (cfgN_q && pace)
                begin
                    taken_d = taken_q + 1'b1;
                    // pre-trigger runs on past the count; only the event or a stop command ends it
                    lastHit = (taken_q + 1'b1) >= count_q && trig_q != TRG_PRE; // RQ11
                    if (lastHit)
                    begin
                        state_d = ST_DONE; // RQ8 RQ12 RQ13
                    end
                end
                if (sampleValid && !fifoReady)
                begin
                    ovf_d = 1'b1;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        if (cmdStop && state_q != ST_DONE)
        begin
            state_d = ST_IDLE; // RQ4 RQ19
            pace    = 1'b0;
        end
        if (!cfgN_q && pace)
        begin
            taken_d = taken_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_IDLE;
            div_q   <= '0;
            dly_q   <= '0;
            taken_q <= '0;
            ovf_q   <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            div_q   <= div_d;
            dly_q   <= dly_d;
            taken_q <= taken_d;
            ovf_q   <= ovf_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sample stream; N-sample data is released only by a read command
    logic release_q, release_d;
    logic drain;

    always_comb
    begin
        release_d = release_q;
        if (cmdStart && (state_q == ST_IDLE || state_q == ST_DONE))
        begin
            release_d = 1'b0;
        end
        else if (cmdRead)
        begin
            release_d = 1'b1; // RQ8
        end
        // continuous modes stream straight out; the fifo only holds 32 words
        drain    = !cfgN_q || release_q; // RQ3
        pktValid = fifoValid && drain;
        pkt_d    = pkt_q;
        if (pktValid && pktReady)
        begin
            pkt_d = (pkt_q == 5'(PKT_WORDS - 1)) ? '0 : pkt_q + 1'b1; // RQ3
        end
        pktLast = pkt_q == 5'(PKT_WORDS - 1);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            release_q <= 1'b0;
            pkt_q     <= '0;
        end
        else
        begin
            release_q <= release_d;
            pkt_q     <= pkt_d;
        end
    end

    ats_fifo
    #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    )
    u_fifo
    (
        .clk      (clk),
        .arst_n   (arst_n),
        .inValid  (sampleValid),
        .inReady  (fifoReady),
        .inData   (sampleData),
        .outValid (fifoValid),
        .outReady (pktReady && drain),
        .outData  (pktData),
        .level    ()
    );

    assign convStrobe   = pace;
    assign state        = state_q;
    assign connGrant    = conn_q;
    assign cfgError     = err_q;
    assign samplesTaken = taken_q;
    assign overflow     = ovf_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_stop_idle: assert property (@(posedge clk) disable iff (!arst_n)
        cmdStop && state_q != ST_DONE |=> state_q == ST_IDLE) // RQ19
        else $error("stop did not return to idle");
    a_arm_wait: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_ARMED && !trigFall && !cmdStop |=> state_q == ST_ARMED) // RQ12
        else $error("armed state left without trigger");
    a_fall_edge: assert property (@(posedge clk) disable iff (!arst_n)
        trigFall |-> $past(trigPin, 3) && !$past(trigPin, 2)) // RQ15
        else $error("trigger event without falling edge");
    a_count_stop: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_CONVERT && cfgN_q && lastHit && !cmdStop |=> state_q == ST_DONE) // RQ8
        else $error("count reached but conversion continues");
    a_one_conn: assert property (@(posedge clk) disable iff (!arst_n)
        conn_q && connReq && !connRelease |-> connRefused) // RQ16
        else $error("second connection not refused");
    a_strobe_state: assert property (@(posedge clk) disable iff (!arst_n)
        convStrobe |-> state_q == ST_CONVERT || state_q == ST_ARMED) // RQ2
        else $error("conversion outside active states");
    a_ext_cont: assert property (@(posedge clk) disable iff (!arst_n)
        cmdParam && cfgNSample && cfgTrig == TRG_EXTCK |=> cfgError) // RQ1
        else $error("external clock accepted in N-sample mode");
    a_counter_pin: assert property (@(posedge clk) disable iff (!arst_n)
        cmdParam && cfgTrigIsCounter && cfgTrig != TRG_SOFT |=> cfgError) // RQ17
        else $error("trigger mode accepted with counter input");

    c_cont_run: cover property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_CONVERT && !cfgN_q ##1 cmdStop);
    c_nsamp_done: cover property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_CONVERT ##1 state_q == ST_DONE);
    c_delay_run: cover property (@(posedge clk) disable iff (!arst_n)
        state_q == ST_DELAY ##1 state_q == ST_CONVERT);
endmodule // ats_sequencer
`default_nettype wire
